// file: common/crp_pkg.sv
package crp_pkg;
   // Sync stages for pad inputs
   localparam int SYNC_STAGES = 3;
   // Reset values
   localparam logic RST_CPU_EXT = 1'b0;
   localparam logic RST_PROTECTION_ERROR_FLAG = 1'b0;
   localparam logic RST_HPE = 1'b1;
   localparam logic RST_HOT = 1'b0;
   // Status A field positions
   localparam int STA_CPU_RESET_EXT_FLAG_BIT = 0;
   localparam int STA_PROTECTION_ERROR_FLAG_BIT = 1;
   localparam int STA_WIDTH = 2;
   // Status B field positions
   localparam int STB_HPE_BIT = 0;
   localparam int STB_HOT_BIT = 1;
   localparam int STB_WIDTH = 2;
   typedef enum logic [2:0] {
      CRP_RUN = 3'h1,
      CRP_HELD = 3'h2,
      CRP_EXT = 3'h4
   } crp_state_e;
endpackage

// file: src/crp_pad_sync.sv
`timescale 1ns/1ns
module crp_pad_sync #(
   parameter int STAGES = crp_pkg::SYNC_STAGES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic pad,
   output logic level,
   output logic fall
);
   logic [STAGES-1:0] sync_reg;
   logic level_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         sync_reg <= {STAGES{1'b1}};
      end else begin
         sync_reg <= {sync_reg[STAGES-2:0], pad};
      end
   end

   // Level changes only once the last two stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         level_reg <= 1'b1;
      end else if (sync_reg[STAGES-1] == sync_reg[STAGES-2]) begin
         level_reg <= sync_reg[STAGES-1];
      end
   end

   assign level = level_reg;
   assign fall = level_reg & (sync_reg[STAGES-1] == sync_reg[STAGES-2]) & ~sync_reg[STAGES-1];
endmodule

// file: src/crp_probe_detect.sv
`timescale 1ns/1ns
// Behaviour
// R1: Flag stays set while CPU held extended
// R2: Writing one releases CPU, clears flag
// R3: Writing zero changes nothing
// R4: Protected device refuses release, sets error
// R5: Extension request during reset means cold plug
// R6: Hot-plug detector held in reset
// R7: Debug clock falling edge registers hot plug
// R8: Pad reassigned disables hot plug until reset
// R9: Hot-plug enable status is readable
// R10: Software keeps debug clock pad default
// R11: Protection error sticky until software clears
module crp_probe_detect (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic EXT_REQ,
   input wire logic REL_WR,
   input wire logic REL_DATA,
   input wire logic PROTECTION_ERROR_FLAG_CLR,
   input wire logic SECURE,
   input wire logic PAD_IS_DEBUG,
   input wire logic DBG_CLK_PAD,
   output logic CPU_RESET_HOLD,
   output logic COLD_PLUG,
   output logic HOT_PLUG,
   output logic [crp_pkg::STA_WIDTH-1:0] STATUS_A,
   output logic [crp_pkg::STB_WIDTH-1:0] STATUS_B
);
   crp_pkg::crp_state_e state_reg, state_next;
   logic cpu_reset_ext_flag;
   logic protection_error_flag;
   logic hot_plug_enable_flag;
   logic hot_reg;
   logic cold_reg;
   logic pad_fall;
   logic release_try;
   logic release_ok;
   logic release_refused;

   ////////////////////////////////////////////////////////////
   // Debug clock pad sampling; reset with system (R6)
   crp_pad_sync u_sync (
      .clk(CLOCK),
      .rst(SYS_RST),
      .pad(DBG_CLK_PAD),
      .level(),
      .fall(pad_fall)
   );

   ////////////////////////////////////////////////////////////
   // CPU reset extension sequence
   // Only a one written during extension is an attempt; a zero is dropped here
   assign release_try = REL_WR & REL_DATA & (state_reg == crp_pkg::CRP_EXT); // R3
   // Protection is judged per attempt, so lifting it later needs a new write
   assign release_ok = release_try & ~SECURE; // R2
   assign release_refused = release_try & SECURE; // R4

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         crp_pkg::CRP_HELD: begin
            // Leaving reset: extend only when a request was seen
            state_next = cold_reg ? crp_pkg::CRP_EXT : crp_pkg::CRP_RUN;
         end
         crp_pkg::CRP_EXT: begin
            // Refused attempts stay here; the error flag records them
            if (release_ok) begin // R2 R3
               state_next = crp_pkg::CRP_RUN;
            end
         end
         crp_pkg::CRP_RUN: state_next = crp_pkg::CRP_RUN;
         default: state_next = crp_pkg::CRP_HELD;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         state_reg <= crp_pkg::CRP_HELD;
      end else begin
         state_reg <= state_next;
      end
   end

   // Request sampled while in reset marks cold plug
   // Kept through run so a debugger can tell cold from hot attach
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         cold_reg <= EXT_REQ ? 1'b1 : 1'b0; // R5
      end
   end

   assign cpu_reset_ext_flag = (state_reg == crp_pkg::CRP_EXT); // R1
   assign CPU_RESET_HOLD = (state_reg != crp_pkg::CRP_RUN);
   assign COLD_PLUG = cold_reg;

   // Sticky; a refusal in the clear cycle wins
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         protection_error_flag <= crp_pkg::RST_PROTECTION_ERROR_FLAG;
      end else if (release_refused) begin
         protection_error_flag <= 1'b1; // R4
      end else if (PROTECTION_ERROR_FLAG_CLR) begin
         protection_error_flag <= 1'b0; // R11
      end
   end

   ////////////////////////////////////////////////////////////
   // Hot-plug detection
   // One cycle off the debug function is enough; only reset re-arms
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         hot_plug_enable_flag <= crp_pkg::RST_HPE;
      end else if (!PAD_IS_DEBUG) begin
         hot_plug_enable_flag <= 1'b0; // R8 R10
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         hot_reg <= crp_pkg::RST_HOT; // R6
      end else if (pad_fall && hot_plug_enable_flag && PAD_IS_DEBUG) begin
         hot_reg <= 1'b1; // R7
      end
   end

   assign HOT_PLUG = hot_reg;

   // Field positions come from the package so the status layout lives in one place
   always_comb begin
      STATUS_A = '0;
      STATUS_A[crp_pkg::STA_CPU_RESET_EXT_FLAG_BIT] = cpu_reset_ext_flag; // R1
      STATUS_A[crp_pkg::STA_PROTECTION_ERROR_FLAG_BIT] = protection_error_flag;
   end

   always_comb begin
      STATUS_B = '0;
      STATUS_B[crp_pkg::STB_HPE_BIT] = hot_plug_enable_flag; // R9
      STATUS_B[crp_pkg::STB_HOT_BIT] = hot_reg;
   end

   ////////////////////////////////////////////////////////////
   // Checks
   // Named behaviours, two of them multi-step; each takes its clock from the property using it
   sequence s_cold_entry;
      (SYS_RST && EXT_REQ) ##1 !SYS_RST;
   endsequence

   sequence s_warm_entry;
      (SYS_RST && !EXT_REQ) ##1 !SYS_RST;
   endsequence

   sequence s_release_ok;
      STATUS_A[0] && REL_WR && REL_DATA && !SECURE;
   endsequence

   sequence s_zero_write;
      STATUS_A[0] && REL_WR && !REL_DATA;
   endsequence

   sequence s_refused_try;
      STATUS_A[0] && REL_WR && REL_DATA && SECURE;
   endsequence

   sequence s_refused_clear;
      STATUS_A[0] && REL_WR && REL_DATA && SECURE && PROTECTION_ERROR_FLAG_CLR;
   endsequence

   sequence s_hot_edge;
      pad_fall && STATUS_B[0] && PAD_IS_DEBUG;
   endsequence

   // Extension and release; reset disables those whose flags reload then
   a_flag_held: assert property (@(posedge CLOCK) disable iff (SYS_RST) // R1
      (STATUS_A[0] && !(REL_WR && REL_DATA && !SECURE)) |=> STATUS_A[0])
      else $error("extension flag dropped without release");
   a_hold_reset: assert property (@(posedge CLOCK) SYS_RST |=> CPU_RESET_HOLD) // R1
      else $error("CPU not held during reset");
   a_release_clears: assert property (@(posedge CLOCK) disable iff (SYS_RST) // R2
      s_release_ok |=> !STATUS_A[0] && !CPU_RESET_HOLD)
      else $error("release did not clear flag");
   a_zero_write: assert property (@(posedge CLOCK) disable iff (SYS_RST) // R3
      s_zero_write |=> STATUS_A[0] && CPU_RESET_HOLD)
      else $error("zero write changed flag");

   // Cold plug is decided once, at the edge that ends reset
   a_cold_extends: assert property (@(posedge CLOCK) // R5
      s_cold_entry |=> STATUS_A[0] && CPU_RESET_HOLD && COLD_PLUG)
      else $error("cold plug did not extend reset");
   a_warm_runs: assert property (@(posedge CLOCK) // R5
      s_warm_entry |=> !STATUS_A[0] && !CPU_RESET_HOLD && !COLD_PLUG)
      else $error("reset extended without a request");
   a_cold_stable: assert property (@(posedge CLOCK) disable iff (SYS_RST) // R5
      !$past(SYS_RST) |-> $stable(COLD_PLUG))
      else $error("cold plug flag changed while running");

   // Protection error; a refusal must outlive a clear in the same cycle
   a_secure_refuse: assert property (@(posedge CLOCK) disable iff (SYS_RST) // R4
      s_refused_try |=> STATUS_A[0] && STATUS_A[1] && CPU_RESET_HOLD)
      else $error("protected release not refused");
   a_protection_error_flag_wins: assert property (@(posedge CLOCK) disable iff (SYS_RST) // R4
      s_refused_clear |=> STATUS_A[1])
      else $error("clear beat a refused release");
   a_protection_error_flag_sticky: assert property (@(posedge CLOCK) disable iff (SYS_RST) // R11
      (STATUS_A[1] && !PROTECTION_ERROR_FLAG_CLR) |=> STATUS_A[1])
      else $error("protection error lost");
   a_protection_error_flag_clear: assert property (@(posedge CLOCK) disable iff (SYS_RST) // R11
      (PROTECTION_ERROR_FLAG_CLR && !(STATUS_A[0] && REL_WR && REL_DATA && SECURE)) |=> !STATUS_A[1])
      else $error("protection error not cleared");

   // Hot plug; detector reloads on every reset, so only the reset checks run without a disable
   a_hot_reset: assert property (@(posedge CLOCK) SYS_RST |=> !HOT_PLUG) // R6
      else $error("hot plug set under reset");
   a_hot_seen: assert property (@(posedge CLOCK) disable iff (SYS_RST) // R7
      s_hot_edge |=> HOT_PLUG)
      else $error("falling edge not registered");
   a_hot_sticky: assert property (@(posedge CLOCK) disable iff (SYS_RST) // R7
      HOT_PLUG |=> HOT_PLUG)
      else $error("hot plug flag lost");
   a_hpe_off: assert property (@(posedge CLOCK) disable iff (SYS_RST) // R8
      !PAD_IS_DEBUG |=> !STATUS_B[0] && $stable(HOT_PLUG))
      else $error("hot plug enable kept after pad change");
   a_hpe_sticky: assert property (@(posedge CLOCK) disable iff (SYS_RST) // R8
      !STATUS_B[0] |=> !STATUS_B[0] && $stable(HOT_PLUG))
      else $error("hot plug detection came back without reset");
   a_hpe_restore: assert property (@(posedge CLOCK) SYS_RST |=> STATUS_B[0]) // R8
      else $error("hot plug enable not restored by reset");
endmodule

// file: sim/crp_probe_model.sv
`timescale 1ns/1ns
module crp_probe_model (
   input wire logic go,
   output logic swclk
);
   // Idles high and stands still between frames
   initial swclk = 1'h1;
   always begin
      wait (go);
      #80 swclk = 1'h0;
      #80 swclk = 1'h1;
   end
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic CLOCK = 1'h0, SYS_RST = 1'h1, EXT_REQ = 1'h1, REL_WR = 1'h0, REL_DATA = 1'h0;
   logic PROTECTION_ERROR_FLAG_CLR = 1'h0, SECURE = 1'h0, PAD_IS_DEBUG = 1'h1, go = 1'h0, pad;
   logic hold, cold, hot;
   logic [1:0] sa, sb;
   int mismatches = 0;
   int check_count = 0;
   // Row: write, data, secure, clear, expected status A
   logic [5:0] rows [4] = '{6'h21, 6'h3B, 6'h05, 6'h30};
   always #10 CLOCK = ~CLOCK;
   crp_probe_model probe (.go(go), .swclk(pad));
   crp_probe_detect dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .EXT_REQ(EXT_REQ),
      .REL_WR(REL_WR), .REL_DATA(REL_DATA), .PROTECTION_ERROR_FLAG_CLR(PROTECTION_ERROR_FLAG_CLR), .SECURE(SECURE),
      .PAD_IS_DEBUG(PAD_IS_DEBUG), .DBG_CLK_PAD(pad), .CPU_RESET_HOLD(hold),
      .COLD_PLUG(cold), .HOT_PLUG(hot), .STATUS_A(sa), .STATUS_B(sb));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge CLOCK);
   endtask
   // Go drops before the model's period ends, so one falling edge per frame
   task automatic frame;
      go = 1'h1;
      cyc(4);
      go = 1'h0;
      cyc(12);
   endtask
   task automatic report_and_stop;
      $display("Counts: %0d compares, %0d mismatches", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(3);
      SYS_RST = 1'h0;
      cyc(2);
      chk({hold, cold, sa}, 4'hD);
      for (int i = 0; i < 4; i++) begin
         {REL_WR, REL_DATA, SECURE, PROTECTION_ERROR_FLAG_CLR} = rows[i][5:2];
         cyc(1);
         REL_WR = 1'h0;
         PROTECTION_ERROR_FLAG_CLR = 1'h0;
         cyc(1);
         chk({hold, 1'h0, sa}, {rows[i][0], 1'h0, rows[i][1:0]});
      end
      frame();
      chk({hot, sb}, 4'h7);
      // Pad toggles under reset; must not count as a hot plug
      SYS_RST = 1'h1;
      EXT_REQ = 1'h0;
      go = 1'h1;
      cyc(4);
      go = 1'h0;
      cyc(4);
      chk({hold, hot, sb}, 4'h9);
      cyc(8);
      SYS_RST = 1'h0;
      cyc(2);
      chk({hold, hot, sb}, 4'h1);
      chk({3'h0, cold}, 4'h0);
      // One cycle off the debug function kills detection until reset
      PAD_IS_DEBUG = 1'h0;
      cyc(1);
      PAD_IS_DEBUG = 1'h1;
      frame();
      chk({hot, sb}, 4'h0);
      // Protected cold plug: refusal and clear in one cycle, error must stay
      SYS_RST = 1'h1;
      EXT_REQ = 1'h1;
      SECURE = 1'h1;
      cyc(3);
      SYS_RST = 1'h0;
      cyc(2);
      chk({hold, cold, sa}, 4'hD);
      chk({hot, sb}, 4'h1);
      {REL_WR, REL_DATA, PROTECTION_ERROR_FLAG_CLR} = 3'h7;
      cyc(1);
      {REL_WR, PROTECTION_ERROR_FLAG_CLR} = 2'h0;
      cyc(1);
      chk({hold, 1'h0, sa}, 4'hB);
      cyc(3);
      chk({hold, 1'h0, sa}, 4'hB);
      PROTECTION_ERROR_FLAG_CLR = 1'h1;
      cyc(1);
      PROTECTION_ERROR_FLAG_CLR = 1'h0;
      cyc(1);
      chk({hold, 1'h0, sa}, 4'h9);
      report_and_stop();
   end
   initial begin
      #20000;
      mismatches++;
      report_and_stop();
   end
endmodule
